// ==== rtl/sas_adc_sequencer.sv ====
module sas_adc_sequencer
  import sas_pkg::*;
#(
  parameter int N_PINS = 13
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  input  wire logic [AW-1:0]     i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic [N_PINS-1:0] i_pin_level,
  input  wire logic              i_cmp_high,
  input  wire logic              i_sleep,
  output logic      [3:0]        o_channel_select,
  output logic                   o_ref_pos_ext,
  output logic                   o_ref_neg_ext,
  output logic                   o_sample,
  output logic                   o_discharge,
  output logic      [9:0]        o_dac_code,
  output logic      [N_PINS-1:0] o_pin_dir,
  output logic                   o_irq,
  output logic                   o_wake
);

  if (N_PINS < 1 || N_PINS > 16)
  begin : g_chk
    $error("N_PINS must be 1 to 16");
  end

  // --------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------
  function automatic logic [8:0] tad_last(input logic [2:0] sel);
    case (sel)
      3'h0:    tad_last = 9'h001;
      3'h4:    tad_last = 9'h003;
      3'h1:    tad_last = 9'h007;
      3'h5:    tad_last = 9'h00F;
      3'h2:    tad_last = 9'h01F;
      3'h6:    tad_last = 9'h03F;
      default: tad_last = RC_TAD_LAST;
    endcase
  endfunction

  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0C;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  function automatic logic [15:0] fmt(input logic [9:0] res,
                                      input logic       right);
    fmt = right ? {6'h00, res} : {res, 6'h00};
  endfunction

  function automatic logic [N_PINS-1:0] merge(
    input logic [N_PINS-1:0] old,
    input logic [31:0]       wd,
    input logic [3:0]        be
  );
    logic [31:0] m;
    m     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m[N_PINS-1:0]) | (wd[N_PINS-1:0] & m[N_PINS-1:0]);
  endfunction

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  sas_state_t        state_reg;
  sas_state_t        state_next;
  logic              wait_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rd_mux;
  logic [15:0]       res_fmt;
  logic              on_reg;
  logic              go_reg;
  logic [3:0]        chan_reg;
  logic [1:0]        ref_reg;
  logic [2:0]        cks_reg;
  logic [2:0]        acq_reg;
  logic              just_reg;
  logic              flag_reg;
  logic              ien_reg;
  logic [N_PINS-1:0] ansel_reg;
  logic [N_PINS-1:0] dir_reg;
  logic [9:0]        result_reg;
  logic [9:0]        sar_reg;
  logic [9:0]        sar_next;
  logic [8:0]        tad_cnt_reg;
  logic [4:0]        step_reg;
  logic [3:0]        bit_idx;
  logic              tick;
  logic              phase_end;
  logic              active;
  logic              sleep_kill;
  logic              abort;
  logic              done;
  logic              bus_wr;
  logic              wr_lo;
  logic              sw_go_set;
  logic              sw_go_clr;
  logic              sample_reg;
  logic              disch_reg;
  logic              irq_reg;
  logic              wake_reg;

  // --------------------------------------------------------------
  // Avalon slave: one wait state per access
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
    if (!i_rst_b)
      wait_reg <= 1'b1;
    else if (i_ce)
      wait_reg <= !((i_avs_read || i_avs_write) && wait_reg);

  assign bus_wr = i_ce && i_avs_write && !wait_reg;
  assign wr_lo  = bus_wr && i_avs_byteenable[0];

  // Justify is applied at read time, so a format change needs no rerun
  assign res_fmt = fmt(result_reg, just_reg);

  always_comb
  begin
    rd_mux = 32'h0;
    case (i_avs_address)
      OFF_CTRL0:
      begin
        rd_mux[ON_POS]        = on_reg;
        rd_mux[GO_POS]        = go_reg;
        rd_mux[CHS_LSB +: 4]  = chan_reg;
      end
      OFF_CTRL1:
      begin
        rd_mux[REFP_POS]      = ref_reg[0];
        rd_mux[REFN_POS]      = ref_reg[1];
      end
      OFF_CTRL2:
      begin
        rd_mux[CKS_LSB +: 3]  = cks_reg;
        rd_mux[ACQ_LSB +: 3]  = acq_reg;
        rd_mux[JUST_POS]      = just_reg;
      end
      OFF_RES_HI: rd_mux[7:0] = res_fmt[15:8];
      OFF_RES_LO: rd_mux[7:0] = res_fmt[7:0];
      OFF_FLAG:   rd_mux[FLAG_POS] = flag_reg;
      OFF_IEN:    rd_mux[IEN_POS]  = ien_reg;
      OFF_PORT:   rd_mux[N_PINS-1:0] = i_pin_level & ~ansel_reg;
      OFF_ANSEL:  rd_mux[N_PINS-1:0] = ansel_reg;
      OFF_DIR:    rd_mux[N_PINS-1:0] = dir_reg;
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      rdata_reg <= 32'h0;
    else if (i_ce && i_avs_read && wait_reg)
      rdata_reg <= rd_mux;

  // --------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk)
    if (!i_rst_b)
    begin
      on_reg   <= 1'b0;
      chan_reg <= CHAN_RST;
      ref_reg  <= REF_RST;
      cks_reg  <= CKS_RST;
      acq_reg  <= ACQ_RST;
      just_reg <= 1'b0;
      ien_reg  <= 1'b0;
    end
    else if (wr_lo)
    begin
      if (i_avs_address == OFF_CTRL0)
      begin
        on_reg   <= i_avs_writedata[ON_POS];
        chan_reg <= i_avs_writedata[CHS_LSB +: 4];
      end
      if (i_avs_address == OFF_CTRL1)
        ref_reg <= {i_avs_writedata[REFN_POS],
                    i_avs_writedata[REFP_POS]};
      if (i_avs_address == OFF_CTRL2)
      begin
        cks_reg  <= i_avs_writedata[CKS_LSB +: 3];
        acq_reg  <= i_avs_writedata[ACQ_LSB +: 3];
        just_reg <= i_avs_writedata[JUST_POS];
      end
      if (i_avs_address == OFF_IEN)
        ien_reg <= i_avs_writedata[IEN_POS];
    end

  // Pin registers only shape port reads and driver outputs
  always_ff @(posedge i_clk)
    if (!i_rst_b)
    begin
      ansel_reg <= PIN_RST[N_PINS-1:0];
      dir_reg   <= PIN_RST[N_PINS-1:0];
    end
    else if (bus_wr)
    begin
      if (i_avs_address == OFF_ANSEL)
        ansel_reg <= merge(ansel_reg, i_avs_writedata, i_avs_byteenable);
      if (i_avs_address == OFF_DIR)
        dir_reg <= merge(dir_reg, i_avs_writedata, i_avs_byteenable);
    end

  // --------------------------------------------------------------
  // Start bit and completion flag
  // --------------------------------------------------------------
  // Start is honoured only once the converter is already on
  assign sw_go_set = wr_lo && i_avs_address == OFF_CTRL0 && on_reg
                     && i_avs_writedata[GO_POS];
  assign sw_go_clr = wr_lo && i_avs_address == OFF_CTRL0
                     && !i_avs_writedata[GO_POS];

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      go_reg <= 1'b0;
    else if (i_ce)
    begin
      if (sw_go_set)
        go_reg <= 1'b1;
      else if (done || sw_go_clr || sleep_kill || !on_reg)
        go_reg <= 1'b0;
    end

  // Write one clears; a completion in the same cycle wins
  always_ff @(posedge i_clk)
    if (!i_rst_b)
      flag_reg <= 1'b0;
    else if (i_ce)
    begin
      if (done)
        flag_reg <= 1'b1;
      else if (wr_lo && i_avs_address == OFF_FLAG
               && i_avs_writedata[FLAG_POS])
        flag_reg <= 1'b0;
    end

  // --------------------------------------------------------------
  // Bit-period clock
  // --------------------------------------------------------------
  // Divided modes count system clocks, so the period follows its rate
  assign tick = tad_cnt_reg >= tad_last(cks_reg);

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      tad_cnt_reg <= 9'h000;
    else if (i_ce)
      // Restart on an abort so discharge still gets two whole periods
      tad_cnt_reg <= (tick || state_reg == SAS_IDLE
                      || state_next != state_reg) ? 9'h000
                     : tad_cnt_reg + 9'h001;

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  assign active     = state_reg == SAS_ACQ || state_reg == SAS_CONV;
  // Only the RC clock keeps running through sleep
  assign sleep_kill = active && i_sleep && cks_reg[1:0] != CLK_RC;
  assign abort      = active && (!go_reg || sleep_kill);
  assign done       = state_reg == SAS_CONV && phase_end && !abort;

  always_comb
  begin
    phase_end = 1'b0;
    unique case (state_reg)
      SAS_IDLE:  phase_end = 1'b0;
      SAS_ACQ:   phase_end = tick && step_reg + 5'h01 >= acq_tads(acq_reg);
      SAS_CONV:  phase_end = tick && step_reg == CONV_LAST;
      SAS_DISCH: phase_end = tick && step_reg == DISCH_LAST;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SAS_IDLE:
        if (go_reg && on_reg)
          state_next = (acq_reg == ACQ_MANUAL) ? SAS_CONV
                       : SAS_ACQ;
      SAS_ACQ:
        if (abort)
          state_next = SAS_DISCH;
        else if (phase_end)
          state_next = SAS_CONV;
      SAS_CONV:
        if (abort || phase_end)
          state_next = SAS_DISCH;
      SAS_DISCH:
        if (phase_end)
          state_next = SAS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      state_reg <= SAS_IDLE;
    else if (i_ce)
      state_reg <= state_next;

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      step_reg <= 5'h00;
    else if (i_ce)
    begin
      if (state_next != state_reg)
        step_reg <= 5'h00;
      else if (tick)
        step_reg <= step_reg + 5'h01;
    end

  // --------------------------------------------------------------
  // Successive approximation
  // --------------------------------------------------------------
  // First period only disconnects the hold cap; then one bit each
  assign bit_idx = 4'(CONV_LAST - step_reg);

  always_comb
  begin
    sar_next = sar_reg;
    if (step_reg == 5'h00)
      sar_next = SAR_MID;
    else
    begin
      sar_next[bit_idx] = i_cmp_high;
      if (bit_idx != 4'h0)
        sar_next[bit_idx - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      sar_reg <= 10'h000;
    else if (i_ce && state_reg == SAS_CONV && tick)
      sar_reg <= sar_next;

  always_ff @(posedge i_clk)
    if (!i_rst_b)
      result_reg <= 10'h000;
    else if (i_ce && done)
      result_reg <= sar_next;

  // --------------------------------------------------------------
  // Analog and system outputs
  // --------------------------------------------------------------
  // Channel routing ignores pin analog-select and direction
  always_ff @(posedge i_clk)
    if (!i_rst_b)
    begin
      sample_reg <= 1'b0;
      disch_reg  <= 1'b0;
      irq_reg    <= 1'b0;
      wake_reg   <= 1'b0;
    end
    else if (i_ce)
    begin
      sample_reg <= on_reg && (state_reg == SAS_IDLE
                    || state_reg == SAS_ACQ);
      disch_reg  <= state_reg == SAS_DISCH;
      irq_reg    <= flag_reg && ien_reg;
      wake_reg   <= flag_reg && ien_reg && i_sleep;
    end

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_channel_select  = chan_reg;
  assign o_ref_pos_ext     = ref_reg[0];
  assign o_ref_neg_ext     = ref_reg[1];
  assign o_sample          = sample_reg;
  assign o_discharge       = disch_reg;
  assign o_dac_code        = sar_reg;
  assign o_pin_dir         = dir_reg;
  assign o_irq             = irq_reg;
  assign o_wake            = wake_reg;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b || !i_ce);

  property p_manual;
    state_reg == SAS_IDLE && go_reg && on_reg && acq_reg == ACQ_MANUAL
    |=> state_reg == SAS_CONV;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual start did not convert");

  property p_auto;
    state_reg == SAS_IDLE && go_reg && on_reg && acq_reg != ACQ_MANUAL
    |=> state_reg == SAS_ACQ;
  endproperty
  a_auto: assert property (p_auto)
    else $error("programmed delay skipped");

  property p_done;
    done && !sw_go_set
    |=> !go_reg && flag_reg && state_reg == SAS_DISCH
        && result_reg == $past(sar_next);
  endproperty
  a_done: assert property (p_done)
    else $error("completion effects missing");

  property p_sticky;
    flag_reg && !(wr_lo && i_avs_address == OFF_FLAG) |=> flag_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag cleared by hardware");

  property p_irq;
    flag_reg && ien_reg ##1 flag_reg && ien_reg |-> o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag raised no interrupt");

  property p_abort;
    state_reg == SAS_CONV && !go_reg
    |=> state_reg == SAS_DISCH && $stable(result_reg);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort changed result");

  property p_go_held;
    state_reg == SAS_ACQ && !sw_go_clr ##1 state_reg == SAS_CONV
    |-> go_reg;
  endproperty
  a_go_held: assert property (p_go_held)
    else $error("start bit dropped between phases");

  property p_port;
    i_avs_read && wait_reg && i_avs_address == OFF_PORT
    |=> (o_avs_readdata[N_PINS-1:0] & ansel_reg) == '0;
  endproperty
  a_port: assert property (p_port)
    else $error("analog pin read nonzero");

  property p_conv_len;
    $rose(state_reg == SAS_CONV) && cks_reg == 3'h0 && !i_avs_write
    |-> (state_reg == SAS_CONV && go_reg) [*8] ##1 state_reg == SAS_CONV;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion ended early");

endmodule

// ==== rtl/sas_pkg.sv ====
package sas_pkg;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         RC_TAD_NS     = 1700;
  localparam int         RC_TAD_CYC    = RC_TAD_NS / CLK_PERIOD_NS;
  localparam logic [8:0] RC_TAD_LAST   = 9'(RC_TAD_CYC - 1);
  localparam logic [4:0] CONV_LAST     = 5'h0A;
  localparam logic [4:0] DISCH_LAST    = 5'h01;
  localparam int         RES_BITS      = 10;
  localparam logic [9:0] SAR_MID       = 10'h200;
  localparam logic [2:0] ACQ_MANUAL    = 3'h0;
  localparam logic [1:0] CLK_RC        = 2'h3;

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam int         AW            = 6;
  localparam logic [5:0] OFF_CTRL0     = 6'h00;
  localparam logic [5:0] OFF_CTRL1     = 6'h04;
  localparam logic [5:0] OFF_CTRL2     = 6'h08;
  localparam logic [5:0] OFF_RES_HI    = 6'h0C;
  localparam logic [5:0] OFF_RES_LO    = 6'h10;
  localparam logic [5:0] OFF_FLAG      = 6'h14;
  localparam logic [5:0] OFF_IEN       = 6'h18;
  localparam logic [5:0] OFF_PORT      = 6'h1C;
  localparam logic [5:0] OFF_ANSEL     = 6'h20;
  localparam logic [5:0] OFF_DIR       = 6'h24;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int         ON_POS        = 0;
  localparam int         GO_POS        = 1;
  localparam int         CHS_LSB       = 2;
  localparam int         REFP_POS      = 0;
  localparam int         REFN_POS      = 1;
  localparam int         CKS_LSB       = 0;
  localparam int         ACQ_LSB       = 3;
  localparam int         JUST_POS      = 7;
  localparam int         FLAG_POS      = 0;
  localparam int         IEN_POS       = 0;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [3:0]  CHAN_RST     = 4'h0;
  localparam logic [1:0]  REF_RST      = 2'h0;
  localparam logic [2:0]  CKS_RST      = 3'h0;
  localparam logic [2:0]  ACQ_RST      = ACQ_MANUAL;
  localparam logic [31:0] PIN_RST      = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    SAS_IDLE  = 2'h0,
    SAS_ACQ   = 2'h1,
    SAS_CONV  = 2'h3,
    SAS_DISCH = 2'h2
  } sas_state_t;

endpackage

// ==== tb/test_sas_adc_sequencer.sv ====
module test_sas_adc_sequencer
  import sas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // Stimulus and design
  // --------------------------------------------------------------
  logic              i_clk;
  logic              i_rst_b;
  logic              i_ce;
  logic [AW-1:0]     i_avs_address;
  logic              i_avs_read;
  logic              i_avs_write;
  logic [31:0]       i_avs_writedata;
  logic [3:0]        i_avs_byteenable;
  logic [31:0]       o_avs_readdata;
  logic              o_avs_waitrequest;
  logic [12:0]       i_pin_level;
  logic              i_cmp_high;
  logic              i_sleep;
  logic [3:0]        o_channel_select;
  logic              o_ref_pos_ext;
  logic              o_ref_neg_ext;
  logic              o_sample;
  logic              o_discharge;
  logic [9:0]        o_dac_code;
  logic [12:0]       o_pin_dir;
  logic              o_irq;
  logic              o_wake;
  logic [9:0]        target;
  logic [9:0]        prev;
  logic [31:0]       q;
  int                miscompares;
  int                total_checks;
  int                cycles;
  int                ta;
  int                tc;
  int                td;
  int                t0;
  int                dv [7]  = '{2, 4, 8, 16, 32, 64, 425};
  logic [2:0]        cks [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int                acq [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  // Comparator stands in for the analog side: bit kept at or above trial
  assign i_cmp_high = (target >= o_dac_code);

  sas_adc_sequencer #(.N_PINS(13)) sas_adc_sequencer_i (
    .i_clk             (i_clk),
    .i_rst_b           (i_rst_b),
    .i_ce              (i_ce),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .i_pin_level       (i_pin_level),
    .i_cmp_high        (i_cmp_high),
    .i_sleep           (i_sleep),
    .o_channel_select  (o_channel_select),
    .o_ref_pos_ext     (o_ref_pos_ext),
    .o_ref_neg_ext     (o_ref_neg_ext),
    .o_sample          (o_sample),
    .o_discharge       (o_discharge),
    .o_dac_code        (o_dac_code),
    .o_pin_dir         (o_pin_dir),
    .o_irq             (o_irq),
    .o_wake            (o_wake)
  );

  always #2 i_clk = ~i_clk;

  // Longest path is the RC clock run, about 8k cycles in all
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One edge passes first so a release never meets a new request
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= ~wr;
    i_avs_writedata <= d;
    do
      @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  // The write lands at the completing edge; outputs settle one edge on
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    @(posedge i_clk);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask

  task automatic chk_res(input logic right, input logic [9:0] v);
    if (right)
    begin
      rd_chk(OFF_RES_HI, {30'h0, v[9:8]});
      rd_chk(OFF_RES_LO, {24'h0, v[7:0]});
    end
    else
    begin
      rd_chk(OFF_RES_HI, {24'h0, v[9:2]});
      rd_chk(OFF_RES_LO, {24'h0, v[1:0], 6'h0});
    end
  endtask

  // Counts acquisition, conversion and discharge lengths in cycles
  task automatic run(input logic [7:0] c2, output int a, output int c,
                     output int d);
    wr(OFF_CTRL2, {24'h0, c2});
    wr(OFF_CTRL0, 32'h17);
    a = 0;
    c = 0;
    d = 0;
    while (o_sample !== 1'b0 && a < 300)
    begin
      @(posedge i_clk);
      a++;
    end
    while (o_discharge !== 1'b1 && c < 6000)
    begin
      @(posedge i_clk);
      c++;
    end
    while (o_discharge === 1'b1 && d < 1000)
    begin
      @(posedge i_clk);
      d++;
    end
  endtask

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_avs_address = '0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hF;
    i_pin_level = 13'h0000;
    i_sleep = 1'b0;
    target = 10'h2A5;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd_chk(OFF_CTRL2, 32'h0);
    rd_chk(OFF_CTRL0, 32'h0);
    rd_chk(6'h3C, 32'h0);
    chk({19'h0, o_pin_dir}, 32'h1FFF);
    wr(OFF_CTRL1, 32'h1);
    chk({o_ref_pos_ext, o_ref_neg_ext}, 2'h2);
    wr(OFF_CTRL1, 32'h2);
    chk({o_ref_pos_ext, o_ref_neg_ext}, 2'h1);
    wr(OFF_CTRL0, 32'h03);
    rd_chk(OFF_CTRL0, 32'h01);
    wr(OFF_CTRL0, 32'h15);
    chk(o_channel_select, 4'h5);
    // Manual acquisition at the fastest divider
    run(8'h00, t0, tc, td);
    chk(tc, 22);
    chk(td, 4);
    repeat (2) @(posedge i_clk);
    chk(o_sample, 1'b1);
    rd_chk(OFF_CTRL0, 32'h15);
    rd_chk(OFF_FLAG, 32'h1);
    chk(o_irq, 1'b0);
    chk_res(1'b0, target);
    for (int k = 0; k < 7; k++)
    begin
      target = 10'h3C1 ^ 10'(k * 37);
      run({k[0], 4'h0, cks[k]}, ta, tc, td);
      chk(tc, 11 * dv[k]);
      chk(td, 2 * dv[k]);
      chk(o_dac_code, target);
      chk_res(k[0], target);
    end
    for (int j = 1; j < 8; j++)
    begin
      target = 10'h100 + 10'(j);
      run({2'h0, 3'(j), 3'h0}, ta, tc, td);
      chk(ta, t0 + 2 * acq[j]);
      chk(tc, 22);
      chk_res(1'b0, target);
    end
    prev = target;
    wr(OFF_IEN, 32'h1);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 1'b1);
    i_sleep <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(o_wake, 1'b1);
    i_sleep <= 1'b0;
    repeat (50) @(posedge i_clk);
    rd_chk(OFF_FLAG, 32'h1);
    wr(OFF_FLAG, 32'h1);
    rd_chk(OFF_FLAG, 32'h0);
    chk(o_irq, 1'b0);
    // Abort in mid-conversion leaves the previous result in place
    target = 10'h05A;
    wr(OFF_CTRL2, 32'h06);
    wr(OFF_CTRL0, 32'h17);
    ta = 0;
    while (o_sample !== 1'b0 && ta < 300)
    begin
      @(posedge i_clk);
      ta++;
    end
    repeat (40) @(posedge i_clk);
    wr(OFF_CTRL0, 32'h15);
    tc = 0;
    td = 0;
    while (o_discharge !== 1'b1 && tc < 100)
    begin
      @(posedge i_clk);
      tc++;
    end
    while (o_discharge === 1'b1 && td < 1000)
    begin
      @(posedge i_clk);
      td++;
    end
    chk(td, 128);
    chk_res(1'b0, prev);
    i_pin_level <= 13'h1FFF;
    wr(OFF_ANSEL, 32'h00F0);
    rd_chk(OFF_PORT, 32'h1F0F);
    wr(OFF_DIR, 32'h0A5A);
    chk({19'h0, o_pin_dir}, 32'h0A5A);
    wrap_up();
  end
endmodule
